// ---- include/ord_pkg.sv ----
// Purpose: shared constants and carriers of the over-range detector
// Assumes: 8-bit signed samples, classic Wishbone with 32-bit data
// Notes: flag vector order is a_high, a_low, b_high, b_low
package ord_pkg;
    localparam int ORD_SAMPLE_W = 8;
    localparam int ORD_MAG_W = ORD_SAMPLE_W - 1;
    localparam int ORD_SEL_W = 3;
    localparam int ORD_CNT_W = 11;
    // stretch length is base << select, 8..1024 device-clock cycles
    localparam logic [ORD_CNT_W-1:0] ORD_STRETCH_BASE = 11'h008;
    localparam int ORD_ADR_W = 8;
    localparam logic [ORD_ADR_W-1:0] ORD_REG_LIMITS = 8'h00;
    localparam logic [ORD_ADR_W-1:0] ORD_REG_CTRL = 8'h04;
    localparam logic [ORD_ADR_W-1:0] ORD_REG_STATUS = 8'h08;
    // limits register fields
    localparam int ORD_HIGH_LSB = 0;
    localparam int ORD_LOW_LSB = 8;
    // control register fields
    localparam int ORD_SEL_LSB = 0;
    localparam int ORD_MODE_BIT = 4;
    // reset values
    localparam logic [ORD_MAG_W-1:0] ORD_HIGH_RST = 7'h7f;
    localparam logic [ORD_MAG_W-1:0] ORD_LOW_RST = 7'h7f;
    localparam logic [ORD_SEL_W-1:0] ORD_SEL_RST = 3'h0;
    localparam int ORD_A_HIGH = 0;
    localparam int ORD_A_LOW = 1;
    localparam int ORD_B_HIGH = 2;
    localparam int ORD_B_LOW = 3;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ORD_ADR_W-1:0] adr;
        logic [31:0] dat;
    } ord_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ord_wb_rsp_t;

    typedef struct packed {
        logic chan_b_low_flag;
        logic chan_b_high_flag;
        logic chan_a_low_flag;
        logic chan_a_high_flag;
    } ord_flags_t;
endpackage : ord_pkg

// ---- verilog/ord_top.sv ----
// Purpose: over-range detector with pulse-stretched status outputs
// Assumes: two samples per clock: lane a and lane b, synchronous inputs
// Notes: lane b is channel B in dual mode, falling-edge sample in single
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: each sample magnitude at or above a limit raises that limit's flag.
// R2: both channels are checked against the one shared pair of limits.
// R3: magnitude maps 0 to 0, +127 to 127, -112 to 112 and -128 to 127.
// R4: in dual mode lane a drives the A flags and lane b the B flags.
// R5: in single mode each limit's status is split over its A and B outputs.
// R6: in single mode the receiver ORs the A and B outputs of each limit.
// R7: each output stays high 8 << select cycles after the latest event.
// R8: the receiver lowers gain on high trips, raises it while low stays off.
// R9: dual mode checks rising-edge samples only, single mode both edges.
// R10: reset clears flags and counters; a new event restarts the count.
module ord_top #(
    parameter int SAMPLE_W = ord_pkg::ORD_SAMPLE_W
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // sample lanes
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] sample_a,
    input wire logic [SAMPLE_W-1:0] sample_b,
    // register bus
    input wire ord_pkg::ord_wb_req_t wb_req,
    output var ord_pkg::ord_wb_rsp_t wb_rsp,
    // status outputs
    output var ord_pkg::ord_flags_t flags
);
    import ord_pkg::*;

    localparam int MAG_W = SAMPLE_W - 1;

    logic rst_meta;
    logic rst_n;
    logic [MAG_W-1:0] high_limit;
    logic [MAG_W-1:0] low_limit;
    logic [ORD_SEL_W-1:0] pulse_stretch_select;
    logic single_mode;
    logic [MAG_W-1:0] mag_a;
    logic [MAG_W-1:0] mag_b;
    logic [3:0] hit;
    logic [3:0] flag_q;
    logic [ORD_CNT_W-1:0] cnt [4];
    logic [ORD_CNT_W-1:0] reload;
    logic bus_req;
    logic bus_wr;

    // magnitude of a signed sample, the most negative code saturates
    function automatic logic [MAG_W-1:0] magnitude(
        input logic [SAMPLE_W-1:0] s
    );
        logic [SAMPLE_W-1:0] neg;
        neg = '0;
        if (!s[SAMPLE_W-1]) begin
            return s[MAG_W-1:0];
        end
        neg = ~s + 1'b1;
        if (neg[SAMPLE_W-1]) begin
            return '1; // [R3]
        end
        return neg[MAG_W-1:0]; // [R3]
    endfunction : magnitude

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign mag_a = magnitude(sample_a);
    assign mag_b = magnitude(sample_b);

    // one limit pair for both lanes; lane b carries the falling-edge
    // sample in single mode so both edges are checked
    always_comb begin
        hit[ORD_A_HIGH] = sample_valid && (mag_a >= high_limit); // [R1] [R2]
        hit[ORD_A_LOW] = sample_valid && (mag_a >= low_limit); // [R1] [R2]
        hit[ORD_B_HIGH] = sample_valid && (mag_b >= high_limit); // [R2] [R9]
        hit[ORD_B_LOW] = sample_valid && (mag_b >= low_limit); // [R2] [R9]
    end

    assign reload = ORD_CNT_W'(ORD_STRETCH_BASE << pulse_stretch_select) - 1'b1;

    // pulse stretchers, one per output
    for (genvar i = 0; i < 4; i++) begin : g_stretch
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                flag_q[i] <= 1'b0;
                cnt[i] <= '0;
            end else if (!rst_n) begin
                flag_q[i] <= 1'b0; // [R10]
                cnt[i] <= '0; // [R10]
            end else if (ce) begin
                if (hit[i]) begin
                    flag_q[i] <= 1'b1; // [R1] [R7]
                    cnt[i] <= reload; // [R7] [R10]
                end else if (cnt[i] != '0) begin
                    cnt[i] <= cnt[i] - 1'b1; // [R7]
                end else begin
                    flag_q[i] <= 1'b0; // [R1] [R7]
                end
            end
        end
    end

    // lane-to-pin mapping is the same in both modes; in single mode the
    // pair of pins for a limit together forms that limit's status
    always_comb begin
        flags.chan_a_high_flag = flag_q[ORD_A_HIGH]; // [R4] [R5]
        flags.chan_a_low_flag = flag_q[ORD_A_LOW]; // [R4] [R5]
        flags.chan_b_high_flag = flag_q[ORD_B_HIGH]; // [R4] [R5]
        flags.chan_b_low_flag = flag_q[ORD_B_LOW]; // [R4] [R5]
    end

    // wishbone slave: one wait state, ack drops the cycle after
    assign bus_req = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    assign bus_wr = bus_req && wb_req.we;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_rsp <= '0;
        end else if (!rst_n) begin
            wb_rsp <= '0;
        end else if (ce) begin
            wb_rsp.ack <= bus_req;
            wb_rsp.dat <= '0;
            if (bus_req && !wb_req.we) begin
                case (wb_req.adr)
                    ORD_REG_LIMITS: begin
                        wb_rsp.dat[ORD_HIGH_LSB +: MAG_W] <= high_limit;
                        wb_rsp.dat[ORD_LOW_LSB +: MAG_W] <= low_limit;
                    end
                    ORD_REG_CTRL: begin
                        wb_rsp.dat[ORD_SEL_LSB +: ORD_SEL_W] <=
                            pulse_stretch_select;
                        wb_rsp.dat[ORD_MODE_BIT] <= single_mode;
                    end
                    ORD_REG_STATUS: begin
                        wb_rsp.dat[3:0] <= flag_q;
                    end
                    default: begin
                        wb_rsp.dat <= '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_limit <= ORD_HIGH_RST;
            low_limit <= ORD_LOW_RST;
            pulse_stretch_select <= ORD_SEL_RST;
            single_mode <= 1'b0;
        end else if (!rst_n) begin
            high_limit <= ORD_HIGH_RST;
            low_limit <= ORD_LOW_RST;
            pulse_stretch_select <= ORD_SEL_RST;
            single_mode <= 1'b0;
        end else if (ce && bus_wr) begin
            // byte 0 and byte 1 lanes only; other lanes hold nothing
            if (wb_req.adr == ORD_REG_LIMITS && wb_req.sel[0]) begin
                high_limit <= wb_req.dat[ORD_HIGH_LSB +: MAG_W];
            end
            if (wb_req.adr == ORD_REG_LIMITS && wb_req.sel[1]) begin
                low_limit <= wb_req.dat[ORD_LOW_LSB +: MAG_W];
            end
            if (wb_req.adr == ORD_REG_CTRL && wb_req.sel[0]) begin
                pulse_stretch_select <= wb_req.dat[ORD_SEL_LSB +: ORD_SEL_W];
                single_mode <= wb_req.dat[ORD_MODE_BIT];
            end
        end
    end

    // checks
    sequence quiet_ah;
        ce && !hit[ORD_A_HIGH];
    endsequence

    sequence trip_ah_short;
        ce && hit[ORD_A_HIGH] && pulse_stretch_select == 3'h0;
    endsequence

    threshold_hit_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        ce && sample_valid && mag_a >= high_limit |=> flags.chan_a_high_flag)
        else $error("high limit hit on lane a not flagged");

    shared_limit_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        ce && sample_valid && mag_b >= low_limit |=> flags.chan_b_low_flag)
        else $error("low limit hit on lane b not flagged");

    saturate_mag_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        sample_a == 8'h80 |-> mag_a == 7'h7f)
        else $error("most negative code does not saturate");

    neg_mag_b_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        sample_b == 8'h90 |-> mag_b == 7'h70)
        else $error("lane b magnitude of -112 is wrong");

    lane_a_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        $rose(flags.chan_a_low_flag) |-> $past(ce && hit[ORD_A_LOW]))
        else $error("a low flag rose without a lane a event");

    lane_b_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        $rose(flags.chan_b_high_flag) |->
            $past(ce && sample_valid && mag_b >= high_limit))
        else $error("b high flag rose without a lane b event");

    stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        trip_ah_short ##1 quiet_ah [*6] |=> flags.chan_a_high_flag)
        else $error("stretched pulse ended early");

    stretch_end_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        trip_ah_short ##1 quiet_ah [*8] |=> !flags.chan_a_high_flag)
        else $error("stretched pulse too long");

    freeze_state_a: assert property (@(posedge clk) disable iff (!rst_n) // clock enable low holds every flag
        !ce |=> $stable(flags))
        else $error("flags moved while clock enable low");

    reset_clear_a: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
        !rst_n |=> flags == '0 && cnt[ORD_A_HIGH] == '0)
        else $error("flags not cleared by reset");

    restart_count_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        ce && hit[ORD_B_LOW] && flag_q[ORD_B_LOW] |=>
            cnt[ORD_B_LOW] == $past(reload))
        else $error("new event did not restart count");
endmodule : ord_top

`default_nettype wire

// ---- tb/ord_gain_model.sv ----
// Purpose: downstream gain-control model fed by the status outputs
// Assumes: flags are synchronous to clk
// Notes: gain steps by one, no saturation
`timescale 1ns/1ns
`default_nettype none
module ord_gain_model #(
    parameter int QUIET = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // detector status
    input wire ord_pkg::ord_flags_t flags,
    // gain setting
    output logic [7:0] gain
);
    import ord_pkg::*;
    logic hi_trip;
    logic lo_trip;
    int quiet_cnt;
    // split status: either lane of a limit counts
    assign hi_trip = flags.chan_a_high_flag | flags.chan_b_high_flag;
    assign lo_trip = flags.chan_a_low_flag | flags.chan_b_low_flag;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain <= 8'h80;
            quiet_cnt <= 0;
        end else if (hi_trip) begin
            gain <= gain - 8'h01;
            quiet_cnt <= 0;
        end else if (lo_trip) begin
            quiet_cnt <= 0;
        end else if (quiet_cnt == QUIET) begin
            gain <= gain + 8'h01;
            quiet_cnt <= 0;
        end else begin
            quiet_cnt <= quiet_cnt + 1;
        end
    end
endmodule : ord_gain_model
`default_nettype wire

// ---- tb/ord_top_tb.sv ----
// Purpose: self-checking bench of the over-range detector
// Assumes: 50 MHz clock, registers over classic Wishbone
// Notes: pulse lengths are counted on falling edges, where flags settle
`timescale 1ns/1ns
`default_nettype none
module ord_top_tb;
    import ord_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic sample_valid = 1'b0;
    logic [7:0] sample_a = 8'h00;
    logic [7:0] sample_b = 8'h00;
    ord_wb_req_t wb_req = '0;
    ord_wb_rsp_t wb_rsp;
    ord_flags_t flags;
    logic [7:0] gain;
    logic [31:0] rd;
    logic [6:0] hi = 7'h7f;
    logic [6:0] lo = 7'h7f;
    int miscompares = 0;
    int check_count = 0;
    always #10 clk = ~clk;
    ord_top dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
        .sample_valid(sample_valid), .sample_a(sample_a),
        .sample_b(sample_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .flags(flags));
    ord_gain_model gain_u (.clk(clk), .rst_n(arst_n), .flags(flags),
        .gain(gain));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        int n;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr,
                    dat: dat};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        if (wb_rsp.ack !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask : rdchk
    function automatic logic [6:0] mag(input logic [7:0] s);
        logic [7:0] neg;
        neg = -s;
        if (s == 8'h80) return 7'h7f;
        return s[7] ? neg[6:0] : s[6:0];
    endfunction : mag
    task automatic samp(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_a <= a;
        sample_b <= b;
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask : samp
    // counts negedges until every flag is low again
    task automatic run_out(input int len);
        int n;
        n = 0;
        while (flags !== 4'h0 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        check(n, len);
    endtask : run_out
    // flags must rise one cycle after the sample and last len cycles
    task automatic hit(input logic [7:0] a, input logic [7:0] b,
                       input int len);
        logic [3:0] exp;
        exp = {mag(b) >= lo, mag(b) >= hi, mag(a) >= lo, mag(a) >= hi};
        samp(a, b);
        @(negedge clk);
        check({28'h0, flags}, {28'h0, exp});
        if (exp != 4'h0) run_out(len);
    endtask : hit
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(ORD_REG_LIMITS, 32'h0000_7f7f);
        rdchk(ORD_REG_CTRL, 32'h0);
        rdchk(ORD_REG_STATUS, 32'h0);
        rdchk(8'h3c, 32'h0);
        // 228 keeps only its low 7 bits: high limit 100, low limit 64
        wb(1'b1, ORD_REG_LIMITS, 32'h0000_40e4);
        hi = 7'h64;
        lo = 7'h40;
        rdchk(ORD_REG_LIMITS, 32'h0000_4064);
        hit(8'h81, 8'h00, 8);
        hit(8'h00, 8'h80, 8);
        hit(8'h40, 8'hc0, 8);
        hit(8'h3f, 8'hc1, 8);
        hit(8'h64, 8'h9c, 8);
        samp(8'h81, 8'h7f);
        rdchk(ORD_REG_STATUS, 32'hf);
        wb(1'b1, ORD_REG_STATUS, 32'h0);
        repeat (12) @(posedge clk);
        rdchk(ORD_REG_STATUS, 32'h0);
        wb(1'b1, ORD_REG_LIMITS, 32'h0000_7170);
        hi = 7'h70;
        lo = 7'h71;
        hit(8'h90, 8'h90, 8);
        for (int s = 0; s < 8; s++) begin
            wb(1'b1, ORD_REG_CTRL, 32'(s));
            hit(8'h7f, 8'h00, 8 << s);
        end
        wb(1'b1, ORD_REG_CTRL, 32'h10);
        rdchk(ORD_REG_CTRL, 32'h10);
        samp(8'h80, 8'h80);
        repeat (3) @(posedge clk);
        hit(8'h80, 8'h80, 8);
        hit(8'h00, 8'h85, 8);
        // enable low must freeze the stretch mid-pulse
        samp(8'h7f, 8'h00);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        check({28'h0, flags}, 32'h3);
        run_out(8);
        // reset in mid-pulse clears flags and registers
        samp(8'h7f, 8'h7f);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({28'h0, flags}, 32'h0);
        rdchk(ORD_REG_CTRL, 32'h0);
        rdchk(ORD_REG_LIMITS, 32'h0000_7f7f);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : ord_top_tb
`default_nettype wire
